// [src/spm_cfg.svh]
// constants for the serial port protocol manager: offsets, codes, timing
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_A_CTRL 8'h00
`define SPM_A_STAT 8'h04
`define SPM_A_MODE 8'h08
`define SPM_A_CPU 8'h0C
`define SPM_A_PORT 8'h10
`define SPM_A_SPTR 8'h14
`define SPM_RST_MODE 8'h33
`define SPM_RST_STN 16'h0001
`define SPM_RST_T3 8'h32
`define SPM_RST_TMO 2'h0
`define SPM_RST_RATE 4'h5
`define SPM_PROTO_OFF 3'h0
`define SPM_PROTO_PROG 3'h1
`define SPM_PROTO_RTU 3'h3
`define SPM_PROTO_SIO 3'h5
`define SPM_PROTO_STNMGR 3'h6
`define SPM_TMO_NONE 2'h3
`define SPM_CMD_SETUP 16'hFFF0
`define SPM_MODE_SLAVE 16'h0000
`define SPM_LEN_OLD 16'h0010
`define SPM_LEN_NEW 16'h0012
`define SPM_MEM_REG 16'h0008
`define SPM_ST_OK 16'h0001
`define SPM_MAJ_LOCAL 8'h0C
`define SPM_MIN_WAIT 8'h01
`define SPM_MIN_UNSUP 8'h02
`define SPM_MIN_MEMTYPE 8'h06
`define SPM_MIN_SHORT 8'h0C
`define SPM_MIN_INVAL 8'h0E
`define SPM_PROG_RATE_LO 16'h0004
`define SPM_PROG_RATE_HI 16'h0007
`define SPM_RTU_RATE_LO 16'h0002
`define SPM_RTU_RATE_HI 16'h0008
`define SPM_STN_LO 16'h0001
`define SPM_STN_HI 16'h00F7
`define SPM_W_LEN 5'h00
`define SPM_W_WAIT 5'h01
`define SPM_W_MEMT 5'h02
`define SPM_W_SOFF 5'h03
`define SPM_W_CMD 5'h06
`define SPM_W_PROTO 5'h07
`define SPM_W_MODE 5'h08
`define SPM_W_RATE 5'h09
`define SPM_W_PAR 5'h0A
`define SPM_W_FLOW 5'h0B
`define SPM_W_TURN 5'h0C
`define SPM_W_TMO 5'h0D
`define SPM_W_BITS 5'h0E
`define SPM_W_STOP 5'h0F
`define SPM_W_DUP 5'h11
`define SPM_W_ID0 5'h12
`define SPM_W_ID3 5'h15
`define SPM_W_RXTX 5'h16
`define SPM_W_RTS 5'h17
`define SPM_TICK_MS 10
`define SPM_CLK_KHZ 200000
`define SPM_CONNECT_S 12
`endif

// [src/spm_pkg.sv]
// types shared by the serial port protocol manager
`default_nettype none
package spm_pkg;
  typedef struct packed {
    logic [2:0] proto;
    logic [3:0] rate;
    logic [1:0] parity;
    logic flow;
    logic [7:0] turn;
    logic [1:0] tmo;
    logic stop;
    logic duplex;
    logic [7:0] station;
    logic [63:0] ident;
    logic [7:0] rxtx;
    logic [7:0] rts;
  } spm_cfg_t;
  typedef enum logic [1:0] {SPM_D_IDLE, SPM_D_FETCH, SPM_D_EVAL} spm_dec_t;
  typedef enum logic [1:0] {SPM_P_RUN, SPM_P_WAIT, SPM_P_SESSION} spm_port_t;
endpackage
`default_nettype wire

// [src/spm_blk_mem.sv]
// command block memory, 32 words of 16 bits, registered read
`default_nettype none
module spm_blk_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// [src/spm_port_ctl.sv]
// per-port protocol swap on programmer attach and detach
`default_nettype none
`include "spm_cfg.svh"
module spm_port_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic install,
  input wire spm_pkg::spm_cfg_t new_cfg,
  input wire spm_pkg::spm_cfg_t cpu_cfg,
  input wire logic [7:0] t3_ticks,
  input wire logic prog_tmo_off,
  input wire logic prog_detect,
  input wire logic drop_ok,
  input wire logic prog_link_up,
  input wire logic prog_activity,
  output var spm_pkg::spm_cfg_t active_cfg,
  output logic pending,
  output logic in_session,
  output logic msg_enable,
  output logic link_lost
);
  localparam logic [10:0] CONN_TICKS =
    11'(`SPM_CONNECT_S * 1000 / `SPM_TICK_MS);
  spm_pkg::spm_port_t st, next_st;
  logic [10:0] cnt, next_cnt;
  spm_pkg::spm_cfg_t pend_cfg, rtu_cfg, chosen;
  spm_pkg::spm_cfg_t next_act, next_pend, next_rtu;
  logic next_pending, leave;
  wire accept = prog_detect && drop_ok &&
                active_cfg.proto == `SPM_PROTO_RTU;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_act = active_cfg;
    next_pend = pend_cfg;
    next_pending = pending;
    next_rtu = rtu_cfg;
    leave = 1'b0;
    chosen = install ? new_cfg : (pending ? pend_cfg : rtu_cfg);
    case (st)
      spm_pkg::SPM_P_RUN: begin
        if (install) begin
          next_act = new_cfg;
          if (new_cfg.proto == `SPM_PROTO_RTU) begin
            next_rtu = new_cfg;
          end
        end else if (accept) begin
          next_st = spm_pkg::SPM_P_WAIT;
          next_cnt = 11'h000;
          next_act = cpu_cfg;
        end
      end
      spm_pkg::SPM_P_WAIT: begin
        if (prog_link_up) begin
          next_st = spm_pkg::SPM_P_SESSION;
          next_cnt = 11'h000;
        end else if (tick) begin
          if (cnt == CONN_TICKS - 11'h001) begin
            leave = 1'b1;
          end else begin
            next_cnt = cnt + 11'h001;
          end
        end
      end
      spm_pkg::SPM_P_SESSION: begin
        // silence counted in ticks; with timeouts off removal goes unseen
        if (prog_activity) begin
          next_cnt = 11'h000;
        end else if (tick && !prog_tmo_off) begin
          if (cnt + 11'h001 >= {3'h0, t3_ticks}) begin
            leave = 1'b1;
          end else begin
            next_cnt = cnt + 11'h001;
          end
        end
      end
      default: begin
        next_st = spm_pkg::SPM_P_RUN;
      end
    endcase
    if (st != spm_pkg::SPM_P_RUN && install) begin
      next_pend = new_cfg;
      next_pending = 1'b1;
    end
    if (leave) begin
      next_st = spm_pkg::SPM_P_RUN;
      next_pending = 1'b0;
      next_act = chosen;
      if (chosen.proto == `SPM_PROTO_RTU) begin
        next_rtu = chosen;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= spm_pkg::SPM_P_RUN;
      cnt <= 11'h000;
      active_cfg <= '{proto: `SPM_PROTO_RTU, rate: `SPM_RST_RATE,
                      default: '0};
      rtu_cfg <= '{proto: `SPM_PROTO_RTU, rate: `SPM_RST_RATE,
                   default: '0};
      pend_cfg <= '0;
      pending <= 1'b0;
      in_session <= 1'b0;
      msg_enable <= 1'b1;
      link_lost <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      active_cfg <= next_act;
      rtu_cfg <= next_rtu;
      pend_cfg <= next_pend;
      pending <= next_pending;
      in_session <= next_st != spm_pkg::SPM_P_RUN;
      msg_enable <= !(next_st == spm_pkg::SPM_P_SESSION &&
                      next_cnt != 11'h000);
      link_lost <= leave && st == spm_pkg::SPM_P_WAIT;
    end
  end
endmodule
`default_nettype wire

// [src/spm_port_manager.sv]
// APB port manager: mode check, setup block decoder, two port controllers
// Function
// - reject mode pairs leaving no programmer port
// - reject console port 1 with unusable port 2
// - multidrop id must equal controller station id
// - recognised programmer replaces terminal slave protocol
// - session uses controller-wide station and timing settings
// - no link within 12 s means lost programmer
// - reject commands unsupported by programming slave
// - new protocol during session held pending
// - port silent until link-loss timeout expires
// - removal seen only as programming slave timeout
// - after disconnect install pending else terminal slave
// - FFF0 is setup, protocol 1, slave mode 0
// - programming rates 4..7, parity codes 0..2
// - turnaround codes 0..3, flow control 1 only
// - timeout 0..3, 8-bit chars, stop 0/1
// - identifier words 18..21, earlier char low byte
// - terminal flow 0 hardware, 1 none
// - duplex 0/1, station address 1..247
// - delays 0..255 in 10 ms units
// - status 1 success, else minor high major low
// - bad rate gives major 12 minor 2
//
// Decided for this implementation: the register offsets and the APB register port.
`default_nettype none
`include "spm_cfg.svh"
module spm_port_manager #(
  parameter int TICK_CYCLES = `SPM_TICK_MS * `SPM_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] prog_detect,
  input wire logic [1:0] prog_multidrop,
  input wire logic [31:0] prog_drop_id,
  input wire logic [1:0] prog_link_up,
  input wire logic [1:0] prog_activity,
  output logic [5:0] port_proto,
  output logic [1:0] port_session,
  output logic [1:0] port_pending,
  output logic [1:0] port_msg_enable
);
  // apb bookkeeping
  logic [31:0] rd_mux;
  logic bus_err;
  wire acc = psel && penable;
  wire fire = acc && pready;
  wire wr = fire && pwrite && !pslverr;
  wire mem_sel = paddr[7];
  wire [4:0] mem_idx = paddr[6:2];

  // software-visible state
  logic busy;
  logic dec_port;
  logic [15:0] stat_word;
  logic [15:0] sptr;
  logic cfg_rej;
  logic [1:0] loss;
  logic [7:0] mode_reg;
  logic [15:0] cpu_stn;
  logic [7:0] t3_ticks;
  logic [1:0] cpu_tmo;

  // decoder
  spm_pkg::spm_dec_t dst;
  logic [4:0] idx;
  logic len_new;
  spm_pkg::spm_cfg_t bcfg, next_cfg;
  logic [7:0] w_err;
  logic [15:0] mem_rdata;
  logic [1:0] inst;
  logic inst_mode;

  // tick and ports
  logic [31:0] tick_cnt;
  logic tick;
  spm_pkg::spm_cfg_t act_cfg [2];
  spm_pkg::spm_cfg_t inst_cfg [2];
  spm_pkg::spm_cfg_t cpu_cfg;
  logic [1:0] drop_ok;
  logic [1:0] lost;
  logic [1:0] use_cpu;

  wire hit_ctrl = paddr == `SPM_A_CTRL;
  wire hit_stat = paddr == `SPM_A_STAT;
  wire hit_mode = paddr == `SPM_A_MODE;
  wire hit_cpu = paddr == `SPM_A_CPU;
  wire hit_port = paddr == `SPM_A_PORT;
  wire hit_sptr = paddr == `SPM_A_SPTR;
  wire hit_reg = hit_ctrl || hit_stat || hit_mode || hit_cpu ||
                 hit_port || hit_sptr;
  // the decoder owns the block memory while it runs
  assign bus_err = mem_sel ? (busy || paddr[1:0] != 2'h0) :
                   (!hit_reg || (hit_ctrl && busy && pwrite));

  // port-mode pair check on a configuration store
  wire [2:0] nm1 = pwdata[2:0];
  wire [2:0] nm2 = pwdata[6:4];
  wire un1 = nm1 == `SPM_PROTO_OFF ||
             (nm1 == `SPM_PROTO_SIO && pwdata[3]);
  wire un2 = nm2 == `SPM_PROTO_OFF ||
             (nm2 == `SPM_PROTO_SIO && pwdata[7]);
  wire known1 = nm1 == `SPM_PROTO_OFF || nm1 == `SPM_PROTO_PROG ||
                nm1 == `SPM_PROTO_RTU || nm1 == `SPM_PROTO_SIO ||
                nm1 == `SPM_PROTO_STNMGR;
  wire known2 = nm2 == `SPM_PROTO_OFF || nm2 == `SPM_PROTO_PROG ||
                nm2 == `SPM_PROTO_RTU || nm2 == `SPM_PROTO_SIO;
  wire pair_bad = (un1 && un2) ||
                  (nm1 == `SPM_PROTO_STNMGR && un2) ||
                  !known1 || !known2;
  wire mode_wr = wr && !mem_sel && hit_mode;
  wire mode_ok = mode_wr && !pair_bad && !busy;
  wire go = wr && !mem_sel && hit_ctrl && pwdata[0];

  assign cpu_cfg = '{proto: `SPM_PROTO_PROG, rate: `SPM_RST_RATE,
                     station: cpu_stn[7:0], tmo: cpu_tmo,
                     ident: {48'h0, cpu_stn}, default: '0};

  always_comb begin
    case (1'b1)
      mem_sel: rd_mux = {16'h0000, mem_rdata};
      hit_ctrl: rd_mux = {30'h0, dec_port, 1'b0};
      hit_stat: rd_mux = {12'h000, loss, cfg_rej, busy, stat_word};
      hit_mode: rd_mux = {24'h000000, mode_reg};
      hit_cpu: rd_mux = {6'h00, cpu_tmo, t3_ticks, cpu_stn};
      hit_port: rd_mux = {16'h0000,
                          1'b0, port_msg_enable[1], use_cpu[1],
                          port_session[1], port_pending[1],
                          port_proto[5:3],
                          1'b0, port_msg_enable[0], use_cpu[0],
                          port_session[0], port_pending[0],
                          port_proto[2:0]};
      hit_sptr: rd_mux = {16'h0000, sptr};
      default: rd_mux = 32'h00000000;
    endcase
  end

  spm_blk_mem u_mem (
    .clk(clk),
    .we(wr && mem_sel),
    .addr(busy ? idx : mem_idx),
    .wdata(pwdata[15:0]),
    .rdata(mem_rdata)
  );

  // one wait state on every access: lets block memory reads settle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && bus_err;
      if (acc && !pready) begin
        prdata <= (pwrite || bus_err) ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `SPM_RST_MODE;
      cpu_stn <= `SPM_RST_STN;
      t3_ticks <= `SPM_RST_T3;
      cpu_tmo <= `SPM_RST_TMO;
      cfg_rej <= 1'b0;
      loss <= 2'h0;
    end else begin
      if (mode_ok) begin
        mode_reg <= pwdata[7:0];
      end
      if (wr && !mem_sel && hit_cpu) begin
        cpu_stn <= pwdata[15:0];
        t3_ticks <= pwdata[23:16];
        cpu_tmo <= pwdata[25:24];
      end
      // set wins over write-one-to-clear
      cfg_rej <= (mode_wr && (pair_bad || busy)) ||
                 (cfg_rej && !(wr && hit_stat && pwdata[17]));
      loss <= lost | (loss & ~({2{wr && hit_stat}} & pwdata[19:18]));
    end
  end

  // per-word checks of the setup block
  always_comb begin
    next_cfg = bcfg;
    w_err = 8'h00;
    case (idx)
      `SPM_W_LEN: begin
        if (mem_rdata < `SPM_LEN_OLD) begin
          w_err = `SPM_MIN_SHORT;
        end else if (mem_rdata != `SPM_LEN_OLD &&
                     mem_rdata != `SPM_LEN_NEW) begin
          w_err = `SPM_MIN_INVAL;
        end
      end
      `SPM_W_WAIT: if (mem_rdata != 16'h0000) w_err = `SPM_MIN_WAIT;
      `SPM_W_MEMT: if (mem_rdata != `SPM_MEM_REG) w_err = `SPM_MIN_MEMTYPE;
      `SPM_W_CMD: if (mem_rdata != `SPM_CMD_SETUP) w_err = `SPM_MIN_UNSUP;
      `SPM_W_PROTO: begin
        if (mem_rdata == {13'h0, `SPM_PROTO_PROG} ||
            mem_rdata == {13'h0, `SPM_PROTO_RTU}) begin
          next_cfg.proto = mem_rdata[2:0];
        end else begin
          w_err = `SPM_MIN_INVAL;
        end
      end
      `SPM_W_MODE: if (mem_rdata != `SPM_MODE_SLAVE) w_err = `SPM_MIN_INVAL;
      `SPM_W_RATE: begin
        if (bcfg.proto == `SPM_PROTO_PROG ?
            (mem_rdata >= `SPM_PROG_RATE_LO &&
             mem_rdata <= `SPM_PROG_RATE_HI) :
            (mem_rdata >= `SPM_RTU_RATE_LO &&
             mem_rdata <= `SPM_RTU_RATE_HI)) begin
          next_cfg.rate = mem_rdata[3:0];
        end else begin
          w_err = `SPM_MIN_UNSUP;
        end
      end
      `SPM_W_PAR: begin
        if (mem_rdata > 16'h0002) w_err = `SPM_MIN_INVAL;
        next_cfg.parity = mem_rdata[1:0];
      end
      `SPM_W_FLOW: begin
        if (bcfg.proto == `SPM_PROTO_PROG ? mem_rdata != 16'h0001 :
            mem_rdata > 16'h0001) w_err = `SPM_MIN_INVAL;
        next_cfg.flow = mem_rdata[0];
      end
      `SPM_W_TURN: begin
        if (mem_rdata > (bcfg.proto == `SPM_PROTO_PROG ? 16'h0003 :
            16'h00FF)) w_err = `SPM_MIN_INVAL;
        next_cfg.turn = mem_rdata[7:0];
      end
      `SPM_W_TMO: begin
        if (bcfg.proto == `SPM_PROTO_PROG) begin
          if (mem_rdata > 16'h0003) w_err = `SPM_MIN_INVAL;
          next_cfg.tmo = mem_rdata[1:0];
        end
      end
      `SPM_W_BITS: begin
        if (bcfg.proto == `SPM_PROTO_PROG && mem_rdata != 16'h0001) begin
          w_err = `SPM_MIN_INVAL;
        end
      end
      `SPM_W_STOP: begin
        if (bcfg.proto == `SPM_PROTO_PROG) begin
          if (mem_rdata > 16'h0001) w_err = `SPM_MIN_INVAL;
          next_cfg.stop = mem_rdata[0];
        end
      end
      `SPM_W_DUP: begin
        if (bcfg.proto == `SPM_PROTO_RTU) begin
          if (mem_rdata > 16'h0001) w_err = `SPM_MIN_INVAL;
          next_cfg.duplex = mem_rdata[0];
        end
      end
      `SPM_W_RXTX: begin
        if (bcfg.proto == `SPM_PROTO_RTU) begin
          if (mem_rdata > 16'h00FF) w_err = `SPM_MIN_INVAL;
          next_cfg.rxtx = mem_rdata[7:0];
        end
      end
      `SPM_W_RTS: begin
        if (bcfg.proto == `SPM_PROTO_RTU) begin
          if (mem_rdata > 16'h00FF) w_err = `SPM_MIN_INVAL;
          next_cfg.rts = mem_rdata[7:0];
        end
      end
      default: begin
        if (idx >= `SPM_W_ID0 && idx <= `SPM_W_ID3) begin
          if (bcfg.proto == `SPM_PROTO_PROG) begin
            next_cfg.ident[{idx[1:0] - 2'h2, 4'h0} +: 16] = mem_rdata;
          end else if (idx == `SPM_W_ID0) begin
            if (mem_rdata < `SPM_STN_LO || mem_rdata > `SPM_STN_HI) begin
              w_err = `SPM_MIN_INVAL;
            end
            next_cfg.station = mem_rdata[7:0];
          end
        end
      end
    endcase
  end

  wire [4:0] last_idx = len_new ? `SPM_W_RTS : `SPM_W_ID3;
  wire eval_end = dst == spm_pkg::SPM_D_EVAL &&
                  (w_err != 8'h00 || idx == last_idx);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dst <= spm_pkg::SPM_D_IDLE;
      busy <= 1'b0;
      dec_port <= 1'b0;
      idx <= 5'h00;
      len_new <= 1'b0;
      bcfg <= '0;
      stat_word <= 16'h0000;
      sptr <= 16'h0000;
    end else begin
      case (dst)
        spm_pkg::SPM_D_IDLE: begin
          if (go) begin
            dst <= spm_pkg::SPM_D_FETCH;
            busy <= 1'b1;
            dec_port <= pwdata[1];
            idx <= 5'h00;
            bcfg <= '0;
          end
        end
        spm_pkg::SPM_D_FETCH: dst <= spm_pkg::SPM_D_EVAL;
        spm_pkg::SPM_D_EVAL: begin
          bcfg <= next_cfg;
          if (idx == `SPM_W_LEN) len_new <= mem_rdata == `SPM_LEN_NEW;
          if (idx == `SPM_W_SOFF) sptr <= mem_rdata;
          if (eval_end) begin
            dst <= spm_pkg::SPM_D_IDLE;
            busy <= 1'b0;
            // active configuration only changes on a clean block
            stat_word <= w_err != 8'h00 ? {w_err, `SPM_MAJ_LOCAL} :
                         `SPM_ST_OK;
          end else begin
            dst <= spm_pkg::SPM_D_FETCH;
            idx <= idx + 5'h01;
          end
        end
        default: dst <= spm_pkg::SPM_D_IDLE;
      endcase
    end
  end

  // install strobes: block result or a configuration store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inst <= 2'h0;
      inst_mode <= 1'b0;
    end else begin
      inst[0] <= mode_ok || (eval_end && w_err == 8'h00 && !dec_port);
      inst[1] <= mode_ok || (eval_end && w_err == 8'h00 && dec_port);
      inst_mode <= mode_ok;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 32'(TICK_CYCLES - 1);
      tick_cnt <= tick_cnt == 32'(TICK_CYCLES - 1) ? 32'h00000000 :
                  tick_cnt + 32'h00000001;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign drop_ok[p] = !prog_multidrop[p] ||
                        prog_drop_id[p*16 +: 16] == cpu_stn;
    assign inst_cfg[p] = inst_mode ?
      '{proto: mode_reg[p*4 +: 3], rate: `SPM_RST_RATE, default: '0} :
      bcfg;
    assign port_proto[p*3 +: 3] = act_cfg[p].proto;
    spm_port_ctl u_port (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .install(inst[p]),
      .new_cfg(inst_cfg[p]),
      .cpu_cfg(cpu_cfg),
      .t3_ticks(t3_ticks),
      .prog_tmo_off(cpu_tmo == `SPM_TMO_NONE),
      .prog_detect(prog_detect[p]),
      .drop_ok(drop_ok[p]),
      .prog_link_up(prog_link_up[p]),
      .prog_activity(prog_activity[p]),
      .active_cfg(act_cfg[p]),
      .pending(port_pending[p]),
      .in_session(port_session[p]),
      .msg_enable(port_msg_enable[p]),
      .link_lost(lost[p])
    );
    assign use_cpu[p] = port_session[p];
  end
endmodule
`default_nettype wire

// [test/spm_port_manager_chk.sv]
// port-level assertions for the port manager
`default_nettype none
module spm_port_manager_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] prog_detect,
  input wire logic [1:0] prog_multidrop,
  input wire logic [5:0] port_proto,
  input wire logic [1:0] port_session,
  input wire logic [1:0] port_pending,
  input wire logic [1:0] port_msg_enable
);
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray pslverr");
  property p_wait;
    psel && !penable ##1 psel && penable |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("late pready");
  property p_attach;
    prog_detect[0] && !prog_multidrop[0] && port_proto[2:0] == 3'h3 &&
      !port_session[0] |-> ##[1:2] port_proto[2:0] == 3'h1;
  endproperty
  a_attach: assert property (p_attach) else $error("no swap");
  property p_pend;
    $rose(port_pending[0]) |-> port_session[0] && port_proto[2:0] == 3'h1;
  endproperty
  a_pend: assert property (p_pend) else $error("pending early");
  property p_revert;
    $fell(port_session[0]) && !$past(port_pending[0]) |->
      ##[0:2] port_proto[2:0] == 3'h3;
  endproperty
  a_revert: assert property (p_revert) else $error("no revert");
  property p_pend_clr;
    $fell(port_session[0]) && $past(port_pending[0]) |->
      ##[0:2] !port_pending[0];
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pend kept");
  property p_silent;
    $fell(port_msg_enable[0]) |-> port_session[0];
  endproperty
  a_silent: assert property (p_silent) else $error("mute");
endmodule
bind spm_port_manager spm_port_manager_chk u_chk (.clk, .rst, .psel,
  .penable, .pready, .pslverr, .prog_detect, .prog_multidrop, .port_proto,
  .port_session, .port_pending, .port_msg_enable);
`default_nettype wire

// [test/spm_prog_model.sv]
// programmer stand-in: line events on both ports
`default_nettype none
module spm_prog_model (
  input wire logic clk,
  input wire logic [1:0] attach,
  input wire logic [1:0] link,
  input wire logic [1:0] chatty,
  input wire logic [1:0] multi,
  input wire logic [31:0] drop_id,
  output logic [1:0] prog_detect,
  output logic [1:0] prog_multidrop,
  output logic [31:0] prog_drop_id,
  output logic [1:0] prog_link_up,
  output logic [1:0] prog_activity
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] att_d = 2'h0;
  always_ff @(posedge clk) begin
    att_d <= attach;
  end
  // line settings always match the terminal ones
  assign prog_detect = attach & ~att_d;
  assign prog_multidrop = multi;
  assign prog_drop_id = drop_id;
  assign prog_link_up = link;
  // steady traffic while chatty: with timeouts on, any silent tick already mutes the port
  assign prog_activity = chatty;
endmodule
`default_nettype wire

// [test/serial_port_protocol_manager_tb_top.sv]
// self-checking bench for the serial port protocol manager
`default_nettype none
module serial_port_protocol_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, prog_drop_id, drop_id = 32'h0;
  logic [1:0] attach = 0, link = 0, chatty = 0, multi = 0, prog_detect;
  logic [1:0] prog_multidrop, prog_link_up, prog_activity, port_session;
  logic [1:0] port_pending, port_msg_enable;
  logic [5:0] port_proto;
  logic [64:0] exp_q[$];
  logic [15:0] blk[24];
  logic [7:0] mv[6] = '{8'h00, 8'hD0, 8'h0D, 8'hDD, 8'h06, 8'hD6};
  logic [4:0] ew[9] = '{5'h00, 5'h00, 5'h01, 5'h02, 5'h06, 5'h09, 5'h0A,
    5'h07, 5'h12};
  logic [15:0] ev[9] = '{16'h000F, 16'h0011, 16'h0001, 16'h0007, 16'hFFF1,
    16'h0009, 16'h0003, 16'h0002, 16'h0000};
  logic [15:0] es[9] = '{16'h0C0C, 16'h0E0C, 16'h010C, 16'h060C, 16'h020C,
    16'h020C, 16'h0E0C, 16'h0E0C, 16'h0E0C};
  int n_errors = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  spm_port_manager #(.TICK_CYCLES(20)) u_dut (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_detect,
    .prog_multidrop, .prog_drop_id, .prog_link_up, .prog_activity,
    .port_proto, .port_session, .port_pending, .port_msg_enable);
  spm_prog_model u_prog (.clk, .attach, .link, .chatty, .multi, .drop_id,
    .prog_detect, .prog_multidrop, .prog_drop_id, .prog_link_up,
    .prog_activity);
  task automatic cmp(input logic [64:0] e);
    cmp_count++;
    if (((prdata ^ e[31:0]) & e[63:32]) !== 32'h0 || pslverr !== e[64]) begin
      n_errors++;
      $display("ERROR %0t read %h expected %h", $time, prdata, e[31:0]);
    end
  endtask
  always @(posedge clk) if (pready === 1'b1 && exp_q.size() > 0) begin
    cmp(exp_q.pop_front());
  end
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [64:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0, {1'b0, m, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {1'b0, 64'h0});
  endtask
  task automatic base(input logic [15:0] pr);
    blk = '{default: 16'h0000};
    blk[0] = 16'h0010;
    blk[2] = 16'h0008;
    blk[6] = 16'hFFF0;
    blk[7] = pr;
    blk[9] = 16'h0005;
    blk[11] = 16'h0001;
    blk[14] = 16'h0001;
    blk[18] = 16'h0001;
  endtask
  task automatic setup(input logic pt, input logic [15:0] st);
    for (int k = 0; k < 24; k++) wr(8'h80 + 8'(4 * k), {16'h0, blk[k]});
    wr(8'h00, {30'h0, pt, 1'b1});
    r = 32'h0001_0000;
    while (r[16] !== 1'b0) rd(8'h04, 32'h0, 32'h0);
    rd(8'h04, 32'h0000_FFFF, {16'h0, st});
  endtask
  task automatic pulse(input logic [1:0] md, input logic [31:0] id);
    multi <= md;
    drop_id <= id;
    attach <= 2'h1;
    @(posedge clk);
    attach <= 2'h0;
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400us;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(53732));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08, 32'hFF, 32'h33);
    rd(8'h0C, 32'h03FF_FFFF, 32'h0032_0001);
    rd(8'h10, 32'hFFFF, 32'h4343);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 64'h0});
    foreach (mv[i]) begin
      wr(8'h08, {24'h0, mv[i]});
      rd(8'h08, 32'hFF, 32'h33);
      rd(8'h04, 32'h2_0000, 32'h2_0000);
      wr(8'h04, 32'h2_0000);
    end
    r = {24'h0, 1'($urandom), 7'h53};
    wr(8'h08, r);
    rd(8'h04, 32'h2_0000, 32'h0);
    foreach (ew[i]) begin
      base(16'h0003);
      blk[ew[i]] = ev[i];
      setup(1'b0, es[i]);
    end
    rd(8'h10, 32'hFF, 32'h43);
    base(16'h0001);
    blk[9] = 16'(4 + $urandom % 4);
    blk[10] = 16'($urandom % 3);
    blk[12] = 16'($urandom % 4);
    blk[15] = 16'($urandom % 2);
    wr(8'h0C, 32'h0008_0005);
    pulse(2'h1, 32'h5);
    link <= 2'h1;
    chatty <= 2'h1;
    @(posedge clk);
    link <= 2'h0;
    rd(8'h10, 32'hFF, 32'h71);
    setup(1'b0, 16'h0001);
    rd(8'h10, 32'hFF, 32'h79);
    chatty <= 2'h0;
    repeat (50) @(posedge clk);
    rd(8'h10, 32'hFF, 32'h39);
    while (port_session[0] !== 1'b0) @(posedge clk);
    rd(8'h10, 32'hFF, 32'h41);
    base(16'h0003);
    setup(1'b0, 16'h0001);
    pulse(2'h1, 32'h6);
    rd(8'h10, 32'hFF, 32'h43);
    pulse(2'h0, 32'h0);
    rd(8'h10, 32'h10, 32'h10);
    while (port_session[0] !== 1'b0) @(posedge clk);
    rd(8'h04, 32'h4_0000, 32'h4_0000);
    rd(8'h10, 32'hFF, 32'h43);
    wr(8'h0C, 32'h0308_0005);
    pulse(2'h0, 32'h0);
    link <= 2'h1;
    @(posedge clk);
    link <= 2'h0;
    repeat (400) @(posedge clk);
    rd(8'h10, 32'h50, 32'h50);
    base(16'h0003);
    blk[0] = 16'h0012;
    blk[22] = 16'h0100;
    setup(1'b1, 16'h0E0C);
    blk[22] = 16'h00FF;
    setup(1'b1, 16'h0001);
    rd(8'h10, 32'hFF00, 32'h4300);
    end_of_test();
  end
endmodule
`default_nettype wire
